/* core/asrwt_ctrl.sv */
// Host controller driving an asynchronous 128K x 8 static memory.
// Assumes the memory pins are unclocked; read data passes two flops before use.
// Requests come from logic on the same clock and need no synchroniser.
// Timing counts use the slower grade, which also meets the faster one.
// Functional notes
// - A read holds the write strobe high, the memory selected and output enable low.
// - Write data is valid 25 ns before the ending edge and held until it.
// - The controller never drives the data bus while the memory may still drive it.
// - The strobe pulse lasts at least the data setup plus strobe-to-float delay.
// - Address is set 35 or 40 ns before write end and may change after it.
module asrwt_ctrl
	import asrwt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ASRWT_ADDR_W-1:0] req_addr,
	input wire logic [ASRWT_DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [ASRWT_DATA_W-1:0] rsp_rdata,
	output logic mem_select_low_active_n,
	output logic mem_select_high_active,
	output logic mem_write_n,
	output logic mem_out_en_n,
	output logic [ASRWT_ADDR_W-1:0] mem_addr,
	output logic [ASRWT_DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe,
	input wire logic [ASRWT_DATA_W-1:0] mem_dq_in
);

	asrwt_state_e state_ff, nxt_state;
	logic [ASRWT_CNT_W-1:0] cnt_ff, nxt_cnt;
	asrwt_pins_s pins_ff, nxt_pins;
	logic ready_ff, nxt_ready;
	logic rvalid_ff, nxt_rvalid;
	logic [ASRWT_DATA_W-1:0] rdata_ff, nxt_rdata;
	logic [ASRWT_DATA_W-1:0] dq_meta_ff, dq_sync_ff;

	////////////////////////////////////////////////////////////////
	// Decode
	wire cnt_done = (cnt_ff == '0);
	wire take_req = ready_ff && req_valid;
	// Counter rests at zero; each wait state loads it on entry
	wire [ASRWT_CNT_W-1:0] cnt_dec = cnt_ff - 4'h1;

	// Idle pin set: deselected, strobes high, bus released
	function automatic asrwt_pins_s idle_pins(input logic [ASRWT_ADDR_W-1:0] a);
		asrwt_pins_s p;
		p.select_low_active_n = 1'b1;
		p.select_high_active = 1'b0;
		p.write_n = 1'b1;
		p.out_en_n = 1'b1;
		p.addr = a;
		p.dq_out = '0;
		p.dq_oe = 1'b0;
		return p;
	endfunction

	////////////////////////////////////////////////////////////////
	// Sequencer: one access at a time, deselect between accesses
	// Waits load the counter on entry and the default counts it down
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_done ? cnt_ff : cnt_dec;
		nxt_pins = pins_ff;
		nxt_ready = ready_ff;
		nxt_rvalid = 1'b0;
		nxt_rdata = rdata_ff;
		unique case (state_ff)
			ASRWT_IDLE:
			begin
				if (take_req)
				begin
					nxt_ready = 1'b0;
					nxt_pins.addr = req_addr;
					nxt_pins.select_low_active_n = 1'b0;
					nxt_pins.select_high_active = 1'b1;
					if (req_write)
					begin
						// Address and select settle one cycle before the strobe
						nxt_pins.dq_out = req_wdata;
						nxt_pins.out_en_n = 1'b1; // Keep memory outputs off
						nxt_pins.dq_oe = 1'b1;
						nxt_state = ASRWT_WSET;
					end
					else
					begin
						nxt_pins.write_n = 1'b1;
						nxt_pins.out_en_n = 1'b0;
						nxt_cnt = ASRWT_RD_CNT + 4'h1; // Plus one count for the sync flops
						nxt_state = ASRWT_READ;
					end
				end
			end
			ASRWT_READ:
			begin
				// Select, enable and address stay put for the whole wait,
				// so the memory output path never sees a change mid access
				// Sample after access time plus sync delay
				if (cnt_done)
				begin
					nxt_rdata = dq_sync_ff;
					nxt_rvalid = 1'b1;
					nxt_pins = idle_pins(pins_ff.addr); // Address held to the end
					nxt_cnt = ASRWT_HZ_CNT;
					nxt_state = ASRWT_TURN;
				end
			end
			ASRWT_WSET:
			begin
				// Output enable stays high, so the memory never turns its pins on
				nxt_pins.write_n = 1'b0; // Overlap starts the write
				nxt_cnt = ASRWT_WR_CNT - 4'h1;
				nxt_state = ASRWT_WPUL;
			end
			ASRWT_WPUL:
			begin
				// Pulse covers setup plus float time and address setup
				if (cnt_done)
				begin
					nxt_pins.write_n = 1'b1; // Strobe ends the write
					nxt_state = ASRWT_WEND;
				end
			end
			ASRWT_WEND:
			begin
				// Data and address held one cycle past the ending edge
				// Select and bus drive drop together a cycle after the strobe,
				// so the memory outputs never turn on between the two
				nxt_pins = idle_pins(pins_ff.addr);
				nxt_cnt = ASRWT_HZ_CNT;
				nxt_state = ASRWT_TURN;
			end
			ASRWT_TURN:
			begin
				// Bus turnaround also spaces cycles for cycle time
				// Memory pins float within their float delay, inside this wait
				if (cnt_done)
				begin
					nxt_ready = 1'b1;
					nxt_state = ASRWT_IDLE;
				end
			end
			default:
			begin
				// Illegal codes only after an upset; fall back to a quiet bus
				nxt_pins = idle_pins(pins_ff.addr);
				nxt_ready = 1'b1;
				nxt_state = ASRWT_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// State registers
	// Reset leaves the memory deselected with the bus released
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_ff <= ASRWT_IDLE;
			cnt_ff <= '0;
			pins_ff <= idle_pins('0);
			ready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			pins_ff <= nxt_pins;
			ready_ff <= nxt_ready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
		end
	end

	// Read data synchroniser; first flop feeds only the second
	// The byte is multi-bit: safe only because the sequencer samples it
	// long after the access time, once every bit has settled
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			dq_meta_ff <= '0;
			dq_sync_ff <= '0;
		end
		else
		begin
			dq_meta_ff <= mem_dq_in;
			dq_sync_ff <= dq_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	// No decode sits on a pin, so no glitch can reach the memory
	assign req_ready = ready_ff;
	assign rsp_valid = rvalid_ff;
	assign rsp_rdata = rdata_ff;
	assign mem_select_low_active_n = pins_ff.select_low_active_n;
	assign mem_select_high_active = pins_ff.select_high_active;
	assign mem_write_n = pins_ff.write_n;
	assign mem_out_en_n = pins_ff.out_en_n;
	assign mem_addr = pins_ff.addr;
	assign mem_dq_out = pins_ff.dq_out;
	assign mem_dq_oe = pins_ff.dq_oe;

endmodule // asrwt_ctrl

/* core/asrwt_pkg.sv */
// Package for the asynchronous static memory controller.
// Assumes a single 20 MHz system clock; times in ns turn into cycle counts here.
package asrwt_pkg;
	localparam int ASRWT_CLK_NS = 50;
	localparam int ASRWT_ADDR_W = 17;
	localparam int ASRWT_DATA_W = 8;
	localparam int ASRWT_WORDS = 131072;
	// Read timing, slow grade assumed so both grades work
	localparam int ASRWT_T_AA_NS = 55;
	localparam int ASRWT_T_DOE_NS = 25;
	localparam int ASRWT_T_HZOE_NS = 20;
	// Write timing
	localparam int ASRWT_T_AW_NS = 40;
	localparam int ASRWT_T_SD_NS = 25;
	localparam int ASRWT_T_HZWE_NS = 20;
	localparam int ASRWT_T_PWE_NS = 40;
	localparam int ASRWT_T_WC_NS = 55;
	// Least times round up, never below one cycle
	function automatic int asrwt_cyc(input int ns);
		int c;
		c = (ns + ASRWT_CLK_NS - 1) / ASRWT_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int ASRWT_RD_CYC = asrwt_cyc(ASRWT_T_AA_NS);
	localparam int ASRWT_HZ_CYC = asrwt_cyc(ASRWT_T_HZOE_NS);
	localparam int ASRWT_PWE_A = asrwt_cyc(ASRWT_T_SD_NS + ASRWT_T_HZWE_NS);
	localparam int ASRWT_PWE_B = asrwt_cyc(ASRWT_T_PWE_NS);
	localparam int ASRWT_PWE_C = asrwt_cyc(ASRWT_T_AW_NS);
	localparam int ASRWT_WR_CYC0 = (ASRWT_PWE_A > ASRWT_PWE_B) ? ASRWT_PWE_A : ASRWT_PWE_B;
	localparam int ASRWT_WR_CYC = (ASRWT_WR_CYC0 > ASRWT_PWE_C) ? ASRWT_WR_CYC0 : ASRWT_PWE_C;
	localparam int ASRWT_CNT_W = 4;
	localparam logic [ASRWT_CNT_W-1:0] ASRWT_RD_CNT = ASRWT_CNT_W'(ASRWT_RD_CYC);
	localparam logic [ASRWT_CNT_W-1:0] ASRWT_HZ_CNT = ASRWT_CNT_W'(ASRWT_HZ_CYC);
	localparam logic [ASRWT_CNT_W-1:0] ASRWT_WR_CNT = ASRWT_CNT_W'(ASRWT_WR_CYC);

	// Pins toward the memory
	typedef struct packed {
		logic select_low_active_n;
		logic select_high_active;
		logic write_n;
		logic out_en_n;
		logic [ASRWT_ADDR_W-1:0] addr;
		logic [ASRWT_DATA_W-1:0] dq_out;
		logic dq_oe;
	} asrwt_pins_s;

	typedef enum logic [2:0] {
		ASRWT_IDLE = 3'b000,
		ASRWT_READ = 3'b001,
		ASRWT_WSET = 3'b010,
		ASRWT_WPUL = 3'b011,
		ASRWT_WEND = 3'b100,
		ASRWT_TURN = 3'b101
	} asrwt_state_e;
endpackage : asrwt_pkg

/* test/asrwt_ctrl_sva.sv */
// Pin timing checker for the static memory controller.
// Bound onto asrwt_ctrl; sees its ports only.
module asrwt_ctrl_sva
	import asrwt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic mem_select_low_active_n,
	input wire logic mem_select_high_active,
	input wire logic mem_write_n,
	input wire logic mem_out_en_n,
	input wire logic [ASRWT_ADDR_W-1:0] mem_addr,
	input wire logic [ASRWT_DATA_W-1:0] mem_dq_out,
	input wire logic mem_dq_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Selection and take decodes
	wire logic sel = !mem_select_low_active_n && mem_select_high_active;
	wire logic take = req_valid && req_ready;
	property p_rd_pins; take && !req_write |=> sel && mem_write_n && !mem_out_en_n; endproperty
	a_rd_pins: assert property (p_rd_pins) else $error("read pins wrong");
	property p_rd_rsp; take && !req_write |-> ##[4:6] rsp_valid; endproperty
	a_rd_rsp: assert property (p_rd_rsp) else $error("read answer late");
	property p_rd_end; rsp_valid |-> !sel && mem_out_en_n; endproperty
	a_rd_end: assert property (p_rd_end) else $error("no standby after read");
	property p_wr_sel; !mem_write_n |-> sel && mem_dq_oe && mem_out_en_n; endproperty
	a_wr_sel: assert property (p_wr_sel) else $error("strobe without select");
	property p_wr_hold; !mem_write_n |-> $stable(mem_dq_out) && $stable(mem_addr); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("data moved in pulse");
	property p_wr_end; $rose(mem_write_n) |-> sel && mem_dq_oe ##1 !sel; endproperty
	a_wr_end: assert property (p_wr_end) else $error("write end wrong");
	property p_no_fight; mem_dq_oe |-> mem_out_en_n; endproperty
	a_no_fight: assert property (p_no_fight) else $error("bus contention");
	property p_wr_start; take && req_write |=> sel && mem_write_n && mem_dq_oe ##1 !mem_write_n;
	endproperty
	a_wr_start: assert property (p_wr_start) else $error("write setup wrong");
	c_rd: cover property (take && !req_write);
	c_wr: cover property (take && req_write);
	c_rsp: cover property (rsp_valid);
endmodule // asrwt_ctrl_sva
bind asrwt_ctrl asrwt_ctrl_sva asrwt_ctrl_sva_inst (.*);

/* test/asrwt_sram_model.sv */
// Behavioural 128K x 8 static memory facing the controller.
// Unclocked; returns the wire level seen by the controller.
module asrwt_sram_model
	import asrwt_pkg::*;
(
	input wire asrwt_pins_s pins,
	output logic [ASRWT_DATA_W-1:0] dq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [ASRWT_DATA_W-1:0] mem [ASRWT_WORDS];
	logic [ASRWT_DATA_W-1:0] last = 8'h00;
	// Decodes of selection, write overlap and read drive
	wire logic sel = !pins.select_low_active_n && pins.select_high_active;
	wire logic wr = sel && !pins.write_n;
	wire logic drv = sel && pins.write_n && !pins.out_en_n;
	// Store when the overlap ends, whichever pin ends it
	always @(negedge wr) mem[pins.addr] = pins.dq_out;
	// Keep the last driven byte so a floating bus shows its inverse
	always @* if (drv) last = mem[pins.addr];
	// Slow access time; no pull on the bus
	// Inertial delay also keeps the old byte after an address change
	assign #55 dq = pins.dq_oe ? pins.dq_out : drv ? mem[pins.addr] : ~last;
endmodule // asrwt_sram_model

/* test/async_sram_read_write_timing_tb.sv */
// Self-checking bench for the static memory controller.
// Requests change on falling edges; the model stands for the memory.
module async_sram_read_write_timing_tb
	import asrwt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [ASRWT_ADDR_W-1:0] req_addr = '0;
	logic [ASRWT_DATA_W-1:0] req_wdata = '0;
	logic req_ready;
	logic rsp_valid;
	logic [ASRWT_DATA_W-1:0] rsp_rdata;
	logic [ASRWT_DATA_W-1:0] dq;
	logic [ASRWT_DATA_W-1:0] ref_mem [int];
	wire asrwt_pins_s pins;
	int errors = 0;
	int comparisons = 0;
	always #25 clk_sys = ~clk_sys;
	asrwt_ctrl asrwt_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.mem_select_low_active_n(pins.select_low_active_n),
		.mem_select_high_active(pins.select_high_active), .mem_write_n(pins.write_n),
		.mem_out_en_n(pins.out_en_n), .mem_addr(pins.addr), .mem_dq_out(pins.dq_out),
		.mem_dq_oe(pins.dq_oe), .mem_dq_in(dq));
	asrwt_sram_model asrwt_sram_model_inst (.pins(pins), .dq(dq));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One access; a read of a never written byte becomes a write
	task automatic op(input logic w, input logic [16:0] a, input logic [7:0] d);
		int n;
		n = 0;
		if (!w && !ref_mem.exists(a)) w = 1'b1;
		// One edge between requests, so valid never drops and rises at once
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 20);
		chk({7'h00, req_ready}, 8'h01);
		@(negedge clk_sys);
		req_valid = 1'b0;
		if (w) ref_mem[a] = d;
		else
		begin
			n = 0;
			while (rsp_valid !== 1'b1 && n++ < 10) @(negedge clk_sys);
			chk({7'h00, rsp_valid}, 8'h01);
			chk(rsp_rdata, ref_mem[a]);
		end
	endtask
	task automatic summarize();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// Corners first, then a random mix back to back
	initial
	begin
		void'($urandom(32'h93d7));
		repeat (3) @(negedge clk_sys);
		chk({pins.select_low_active_n, pins.select_high_active, pins.dq_oe}, 8'h04);
		rst = 1'b0;
		op(1'b1, '0, 8'h00);
		op(1'b1, '1, 8'hff);
		op(1'b0, '0, 8'h00);
		op(1'b0, '1, 8'h00);
		$display("test corners done");
		repeat (40) op(1'($urandom), 17'($urandom_range(0, 31)), 8'($urandom));
		$display("test random done");
		summarize();
	end
	// Watchdog: about 45 accesses of 6 or 7 cycles, with wide margin
	initial
	begin
		#(3000 * 50);
		errors++;
		summarize();
	end
endmodule // async_sram_read_write_timing_tb
